//--- bench/pll_analog_model.sv
/*
  Partner model: lock and track detectors of the analog PLL and the clock monitor.
  Assumes the bench commands the wanted levels and the design sends its reinit pulse.
*/
`timescale 1ns/1ps
module pll_analog_model #(
  parameter int RELOCK = 6
) (
  input wire logic clk_i, // bus clock
  input wire logic reinit_i, // restart detection
  input wire logic lock_want_i, // bench: pll on target
  input wire logic track_want_i, // bench: pll tracking
  input wire logic osc_stop_i, // bench: oscillator stopped
  output logic lock_o, // lock detector level
  output logic track_o, // track detector level
  output logic osc_loss_o, // monitor saw loss of clock
  output logic quality_ok_o // quality check passed
);
  int wait_cnt = 0;

  // a restarted detector drops both levels until it has settled again
  always @(posedge clk_i)
  begin
    if (reinit_i)
      wait_cnt <= RELOCK;
    else if (wait_cnt > 0)
      wait_cnt <= wait_cnt - 1;
  end

  // levels as the detectors report them
  assign lock_o = lock_want_i && (wait_cnt == 0);
  assign track_o = track_want_i && (wait_cnt == 0);
  // quality can only pass once the oscillator runs again
  assign osc_loss_o = osc_stop_i;
  assign quality_ok_o = !osc_stop_i;
endmodule : pll_analog_model

//--- bench/tb_clock_gen_status.sv
/*
  Self-checking testbench of clock_gen_status beside the analog partner model.
  Assumes a 40 MHz bus clock and the plain register port of the package.
*/
`timescale 1ns/1ps
module tb_clock_gen_status;
  import clock_gen_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic por_reset_i = 1'b1;
  reg_req_t req = '0;
  logic sel = 1'b0;
  logic mon_en = 1'b0;
  logic self_en = 1'b0;
  logic [3:0] stp = 4'h0; // request, entered, aborted, low voltage
  logic want_lock = 1'b0;
  logic want_track = 1'b0;
  logic osc_stop = 1'b0;
  logic loss, ok, lock, track, reinit, from_pll, self_mode, irq, reinit_seen;
  logic [7:0] rdata, factor;
  logic [5:0] mult;
  logic [3:0] div;
  logic [4:0] div_factor;
  logic [7:0] exp_q[$];
  logic rd_pend = 1'b0;
  logic [31:0] seed = 32'hF51A339B;
  int n_errors = 0;
  int samples_checked = 0;

  always #12.5 clk_i = ~clk_i;

  clock_gen_status i_clock_gen_status (.clk_i(clk_i), .reset_i(reset_i), .por_reset_i(por_reset_i),
    .bus_req_i(req), .rdata_o(rdata), .sysclk_from_pll_select_i(sel), .clock_monitor_enable_i(mon_en),
    .self_clock_enable_i(self_en), .osc_loss_i(loss), .clock_quality_ok_i(ok), .pll_lock_i(lock),
    .pll_track_i(track), .stop_request_write_i(stp[3]), .stop_entered_i(stp[2]),
    .stop_aborted_i(stp[1]), .lvr_event_i(stp[0]), .multiplier_field_o(mult), .ref_div_field_o(div),
    .pll_mult_factor_o(factor), .ref_div_factor_o(div_factor), .detector_reinit_o(reinit),
    .sysclk_from_pll_o(from_pll), .self_clock_mode_o(self_mode), .irq_o(irq));

  pll_analog_model i_pll_analog_model (.clk_i(clk_i), .reinit_i(reinit), .lock_want_i(want_lock),
    .track_want_i(want_track), .osc_stop_i(osc_stop), .lock_o(lock), .track_o(track),
    .osc_loss_o(loss), .quality_ok_o(ok));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic finish_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : finish_test

  // one access, then a gap cycle so no strobe is driven twice in one step
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    req <= '{addr: a, wdata: d, wr: w, rd: !w};
    if (!w)
      exp_q.push_back(e);
    @(posedge clk_i);
    req <= '0;
    @(negedge clk_i);
    reinit_seen = reinit;
    @(posedge clk_i);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 8'h00);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(1'b0, a, 8'h00, e);
  endtask : rd

  task automatic pulse(input logic [3:0] v);
    stp <= v;
    @(posedge clk_i);
    stp <= 4'h0;
    @(posedge clk_i);
  endtask : pulse

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask : idle

  // read data stands only in the cycle after the strobe, so look there
  always @(posedge clk_i)
    rd_pend <= req.rd;
  always @(negedge clk_i)
  begin
    if (rd_pend)
      cmp(rdata, exp_q.pop_front());
  end

  // hang guard, well beyond the few hundred cycles the sequence needs
  initial
  begin
    #(25 * 2000);
    n_errors++;
    finish_test;
  end

  initial
  begin
    idle(20);
    reset_i <= 1'b0;
    por_reset_i <= 1'b0;
    idle(8);
    // reset values, an unmapped place
    rd(8'h00, 8'h00);
    rd(8'h01, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h03, 8'h40);
    // random loop-divider and reference settings
    repeat (4)
    begin
      seed = lfsr(seed);
      wr(8'h00, seed[7:0]);
      cmp({7'h0, reinit_seen}, 8'h01);
      cmp({2'h0, mult}, {2'h0, seed[5:0]});
      cmp(factor, 8'(2 * (seed[5:0] + 1)));
      wr(8'h01, seed[15:8]);
      cmp({4'h0, div}, {4'h0, seed[11:8]});
      cmp({3'h0, div_factor}, {3'h0, 5'(seed[11:8] + 1)});
    end
    // writes are frozen while the clock select bit picks the pll
    sel <= 1'b1;
    wr(8'h00, ~seed[7:0]);
    cmp({7'h0, reinit_seen}, 8'h00);
    wr(8'h01, ~seed[15:8]);
    cmp({7'h0, reinit_seen}, 8'h00);
    cmp({7'h0, from_pll}, 8'h01);
    rd(8'h00, {2'h0, seed[5:0]});
    rd(8'h01, {4'h0, seed[11:8]});
    sel <= 1'b0;
    // lock and track, change flag, write-one clear
    wr(8'h04, 8'hFF);
    rd(8'h04, 8'h12);
    want_lock <= 1'b1;
    idle(8);
    cmp({7'h0, irq}, 8'h01);
    want_track <= 1'b1;
    idle(8);
    rd(8'h03, 8'h5C);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'h5C);
    wr(8'h03, 8'h50);
    cmp({7'h0, irq}, 8'h00);
    rd(8'h03, 8'h0C);
    wr(8'h00, 8'h05);
    idle(12);
    rd(8'h03, 8'h1C);
    wr(8'h03, 8'h10);
    // masked lock request
    wr(8'h04, 8'h02);
    want_lock <= 1'b0;
    idle(8);
    cmp({7'h0, irq}, 8'h00);
    rd(8'h03, 8'h14);
    wr(8'h04, 8'h10);
    cmp({7'h0, irq}, 8'h01);
    wr(8'h03, 8'h10);
    // self-clock mode needs both enables and a lost oscillator
    wr(8'h04, 8'h02);
    osc_stop <= 1'b1;
    for (int k = 1; k < 4; k++)
    begin
      {mon_en, self_en} <= 2'(k);
      idle(8);
      cmp({7'h0, self_mode}, {7'h0, k == 3});
    end
    cmp({7'h0, from_pll}, 8'h01);
    cmp({7'h0, irq}, 8'h01);
    rd(8'h03, 8'h03);
    osc_stop <= 1'b0;
    idle(8);
    rd(8'h03, 8'h06);
    wr(8'h03, 8'h02);
    cmp({7'h0, irq}, 8'h00);
    cmp({7'h0, from_pll}, 8'h00);
    {mon_en, self_en} <= 2'h0;
    // stop entry: unrequested, aborted, completed, cleared
    pulse(4'h4);
    rd(8'h03, 8'h04);
    pulse(4'h8);
    pulse(4'h6);
    rd(8'h03, 8'h04);
    pulse(4'h8);
    pulse(4'h4);
    rd(8'h03, 8'h84);
    wr(8'h03, 8'h80);
    rd(8'h03, 8'h04);
    pulse(4'h8);
    pulse(4'h4);
    pulse(4'h8);
    rd(8'h03, 8'h04);
    // reset causes survive a system reset
    pulse(4'h1);
    rd(8'h03, 8'h24);
    reset_i <= 1'b1;
    idle(3);
    reset_i <= 1'b0;
    idle(8);
    rd(8'h03, 8'h24);
    wr(8'h03, 8'h20);
    rd(8'h03, 8'h04);
    reset_i <= 1'b1;
    por_reset_i <= 1'b1;
    idle(3);
    reset_i <= 1'b0;
    por_reset_i <= 1'b0;
    idle(8);
    rd(8'h03, 8'h44);
    finish_test;
  end
endmodule : tb_clock_gen_status

//--- hw/change_flag.sv
/*
  Sticky flag that sets when a status level changes and clears on a written 1.
  Assumes level_i is already synchronous to clk_i.
*/
`timescale 1ns/1ps
module change_flag (
  input wire logic clk_i, // bus clock
  input wire logic reset_i, // async reset, active high
  input wire logic level_i, // watched status level
  input wire logic clear_i, // software writes 1 to the flag
  output logic flag_o // sticky change flag
);
  logic last_level;
  logic changed;

  assign changed = level_i ^ last_level;

  // a change in the clearing cycle still sets the flag
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      last_level <= 1'b0;
      flag_o <= 1'b0;
    end
    else
    begin
      last_level <= level_i;
      flag_o <= changed | (flag_o & ~clear_i);
    end
  end
endmodule : change_flag

//--- hw/clock_gen_cfg.svh
/*
  Constants for the clock generator control and status slice: register offsets,
  field positions, field widths and reset values.
  Assumes it is included by its bare name from the package and the design modules.
*/
// Functional notes
// - multiplier register ignores writes while system clock comes from the PLL; code freezes it on the select bit only, not in self-clock mode.
// - multiplier field gives PLL output as twice divided reference times field plus one.
// - reference divider ignores writes while system clock comes from the PLL; code freezes it on the select bit only, not in self-clock mode.
// - reference divider field divides the oscillator clock by field plus one.
// - accepted multiplier or divider write reinitialises lock and track detection.
// - stop-entered flag clears on a stop request write or a written 1.
// - stop-entered flag sets only on completed stop entry, not on early wake-up.
// - power-on reset flag sets on power-on only; write 1 clears it.
// - low-voltage reset flag sets on low-voltage reset only; write 1 clears it.
// - lock change flag sets whenever lock status changes; write 1 clears it.
// - interrupt requested while lock change flag and its enable are both set.
// - lock status follows the detector, forced to zero in self-clock mode.
// - track status is one in tracking, zero otherwise and in self-clock mode.
// - self-clock change flag sets whenever self-clock status changes; write 1 clears.
// - interrupt requested while self-clock change flag and its enable are set.
// - self-clock status reads one while clocks run from the free-running PLL.
// - interrupt enable holds lock enable at bit 4, self-clock enable at bit 1.
// - system clock comes from the PLL when selected, else from the oscillator; code also takes it from the PLL in self-clock mode.
// - self-clock mode entered only with monitor and self-clock enabled and clock lost.
`ifndef CLOCK_GEN_CFG_SVH
`define CLOCK_GEN_CFG_SVH

`define OFS_PLL_MULTIPLIER 8'h00
`define OFS_PLL_REFERENCE_DIVIDER 8'h01
`define OFS_CLOCK_GEN_FLAGS 8'h03
`define OFS_CLOCK_GEN_IRQ_ENABLE 8'h04

`define MULT_FIELD_W 6
`define REFDIV_FIELD_W 4
`define MULT_RESET 6'h00
`define REFDIV_RESET 4'h0
`define IRQ_ENABLE_RESET 2'h0

`define BIT_STOP_ENTERED 7
`define BIT_POWER_ON 6
`define BIT_LOW_VOLTAGE 5
`define BIT_LOCK_CHANGE 4
`define BIT_LOCK 3
`define BIT_TRACK 2
`define BIT_SELF_CLOCK_CHANGE 1
`define BIT_SELF_CLOCK 0

`endif

//--- hw/clock_gen_pkg.sv
/*
  Types shared by the clock generator control and status slice.
  Assumes the constants header is on the include path.
*/
package clock_gen_pkg;
  `include "clock_gen_cfg.svh"

  // one register access from software; wr and rd never both high
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // clocking mode of the system, one-hot
  typedef enum logic [1:0] {
    clk_normal = 2'b01,
    clk_self = 2'b10
  } clock_mode_t;

  // tracking of a stop request, one-hot
  typedef enum logic [1:0] {
    stop_idle = 2'b01,
    stop_pending = 2'b10
  } stop_track_t;
endpackage : clock_gen_pkg

//--- hw/clock_gen_status.sv
/*
  Control and status slice of the clock and reset generator: PLL multiplier and
  reference divider, reset-cause and stop flags, lock, track and self-clock status,
  change flags with interrupt enables, and the register port.
  Assumes lock, track, oscillator-loss and clock-quality inputs are asynchronous
  levels; every other input is synchronous to clk_i. The clock select, PLL control
  and stop/doze registers live elsewhere and only hand their bits in here.
*/
`timescale 1ns/1ps
`include "clock_gen_cfg.svh"
module clock_gen_status
  import clock_gen_pkg::*;
(
  input wire logic clk_i, // bus clock, 40 MHz
  input wire logic reset_i, // system reset, async, active high
  input wire logic por_reset_i, // power-on reset, async, active high
  input wire reg_req_t bus_req_i, // register access request
  output logic [7:0] rdata_o, // read data, cycle after the read strobe
  input wire logic sysclk_from_pll_select_i, // clock select bit from its register
  input wire logic clock_monitor_enable_i, // monitor enable from PLL control
  input wire logic self_clock_enable_i, // self-clock enable from PLL control
  input wire logic osc_loss_i, // clock monitor saw the oscillator stop, async
  input wire logic clock_quality_ok_i, // quality check passed, async
  input wire logic pll_lock_i, // lock detector level, async
  input wire logic pll_track_i, // track detector level, async
  input wire logic stop_request_write_i, // pulse: software wrote the stop bit
  input wire logic stop_entered_i, // pulse: stop procedure completed
  input wire logic stop_aborted_i, // pulse: wake-up before stop completed
  input wire logic lvr_event_i, // pulse: low-voltage reset occurred
  output logic [`MULT_FIELD_W-1:0] multiplier_field_o, // loop divider field
  output logic [`REFDIV_FIELD_W-1:0] ref_div_field_o, // reference divider field
  output logic [7:0] pll_mult_factor_o, // 2 x (multiplier + 1)
  output logic [4:0] ref_div_factor_o, // reference divider + 1
  output logic detector_reinit_o, // pulse: restart lock and track detection
  output logic sysclk_from_pll_o, // system clock taken from the PLL
  output logic self_clock_mode_o, // self-clock mode active
  output logic irq_o // combined interrupt request, level
);
  // register decode
  logic hit_mult;
  logic hit_refdiv;
  logic hit_flags;
  logic hit_irq_en;
  logic wr_mult_ok;
  logic wr_refdiv_ok;
  logic wr_flags;
  logic wr_irq_en;
  logic cfg_write;

  // state
  logic [`MULT_FIELD_W-1:0] multiplier;
  logic [`REFDIV_FIELD_W-1:0] ref_div;
  logic lock_change_irq_enable;
  logic self_clock_irq_enable;
  logic lock_status;
  logic track_status;
  logic stop_entered_flag;
  logic power_on_reset_flag;
  logic low_voltage_reset_flag;
  logic lock_change_flag;
  logic self_clock_change_flag;
  logic self_clock_status;
  clock_mode_t clock_mode;
  clock_mode_t next_clock_mode;
  stop_track_t stop_track;
  stop_track_t next_stop_track;

  // synchronised analog levels
  logic [3:0] analog_sync;
  logic lock_sync;
  logic track_sync;
  logic loss_sync;
  logic quality_sync;

  // next values
  logic next_lock_status;
  logic next_track_status;
  logic next_stop_flag;
  logic next_por_flag;
  logic next_lvr_flag;
  logic [7:0] flags_view;
  logic [7:0] irq_en_view;
  logic [7:0] next_rdata;
  logic [6:0] mult_plus_one;
  logic enter_self;

  // analog status crosses into the bus clock before use
  level_sync #(
    .WIDTH(4)
  ) u_analog_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({clock_quality_ok_i, osc_loss_i, pll_track_i, pll_lock_i}),
    .sync_o(analog_sync)
  );

  assign lock_sync = analog_sync[0];
  assign track_sync = analog_sync[1];
  assign loss_sync = analog_sync[2];
  assign quality_sync = analog_sync[3];

  // address decode; plain byte offsets
  assign hit_mult = (bus_req_i.addr == `OFS_PLL_MULTIPLIER);
  assign hit_refdiv = (bus_req_i.addr == `OFS_PLL_REFERENCE_DIVIDER);
  assign hit_flags = (bus_req_i.addr == `OFS_CLOCK_GEN_FLAGS);
  assign hit_irq_en = (bus_req_i.addr == `OFS_CLOCK_GEN_IRQ_ENABLE);

  // PLL settings are frozen while the clock select bit picks the PLL; self-clock mode alone does not freeze them
  assign wr_mult_ok = bus_req_i.wr & hit_mult & ~sysclk_from_pll_select_i;
  assign wr_refdiv_ok = bus_req_i.wr & hit_refdiv & ~sysclk_from_pll_select_i;
  assign wr_flags = bus_req_i.wr & hit_flags;
  assign wr_irq_en = bus_req_i.wr & hit_irq_en;
  assign cfg_write = wr_mult_ok | wr_refdiv_ok;

  // PLL configuration registers; reserved upper bits are not stored
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      multiplier <= `MULT_RESET;
      ref_div <= `REFDIV_RESET;
    end
    else
    begin
      if (wr_mult_ok)
        multiplier <= bus_req_i.wdata[`MULT_FIELD_W-1:0];
      if (wr_refdiv_ok)
        ref_div <= bus_req_i.wdata[`REFDIV_FIELD_W-1:0];
    end
  end

  // factors handed to the analog PLL
  assign multiplier_field_o = multiplier;
  assign ref_div_field_o = ref_div;
  assign mult_plus_one = {1'b0, multiplier} + 7'h01;
  assign pll_mult_factor_o = {mult_plus_one, 1'b0};
  assign ref_div_factor_o = {1'b0, ref_div} + 5'h01;

  // interrupt enables; only two bits exist
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      {lock_change_irq_enable, self_clock_irq_enable} <= `IRQ_ENABLE_RESET;
    end
    else if (wr_irq_en)
    begin
      lock_change_irq_enable <= bus_req_i.wdata[`BIT_LOCK_CHANGE];
      self_clock_irq_enable <= bus_req_i.wdata[`BIT_SELF_CLOCK_CHANGE];
    end
  end

  // self-clock mode: entered on lost clock, left once clock quality returns
  assign enter_self = clock_monitor_enable_i & self_clock_enable_i & loss_sync;
  always_comb
  begin
    next_clock_mode = clock_mode;
    case (clock_mode)
      clk_normal:
        if (enter_self)
          next_clock_mode = clk_self;
      clk_self:
        if (quality_sync & ~loss_sync)
          next_clock_mode = clk_normal;
      default:
        next_clock_mode = clk_normal;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      clock_mode <= clk_normal;
    else
      clock_mode <= next_clock_mode;
  end

  assign self_clock_status = (clock_mode == clk_self);
  assign self_clock_mode_o = self_clock_status;
  // self-clock also runs everything from the PLL, at its lowest frequency
  assign sysclk_from_pll_o = sysclk_from_pll_select_i | self_clock_status;

  // lock and track status; a config write restarts both detectors
  assign next_lock_status = lock_sync & ~self_clock_status & ~cfg_write;
  assign next_track_status = track_sync & ~self_clock_status & ~cfg_write;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      lock_status <= 1'b0;
      track_status <= 1'b0;
      detector_reinit_o <= 1'b0;
    end
    else
    begin
      lock_status <= next_lock_status;
      track_status <= next_track_status;
      detector_reinit_o <= cfg_write;
    end
  end

  // change flags; a change in the clearing cycle still wins
  change_flag u_lock_change (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(lock_status),
    .clear_i(wr_flags & bus_req_i.wdata[`BIT_LOCK_CHANGE]),
    .flag_o(lock_change_flag)
  );

  change_flag u_self_clock_change (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .level_i(self_clock_status),
    .clear_i(wr_flags & bus_req_i.wdata[`BIT_SELF_CLOCK_CHANGE]),
    .flag_o(self_clock_change_flag)
  );

  // stop tracking: an abort by wake-up keeps the flag from setting
  always_comb
  begin
    next_stop_track = stop_track;
    case (stop_track)
      stop_idle:
        if (stop_request_write_i)
          next_stop_track = stop_pending;
      stop_pending:
        if (stop_entered_i | stop_aborted_i)
          next_stop_track = stop_idle;
      default:
        next_stop_track = stop_idle;
    endcase
  end

  // set wins over either clear
  assign next_stop_flag = (stop_entered_i & (stop_track == stop_pending) & ~stop_aborted_i)
    | (stop_entered_flag & ~stop_request_write_i
       & ~(wr_flags & bus_req_i.wdata[`BIT_STOP_ENTERED]));

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      stop_track <= stop_idle;
      stop_entered_flag <= 1'b0;
    end
    else
    begin
      stop_track <= next_stop_track;
      stop_entered_flag <= next_stop_flag;
    end
  end

  // reset-cause flags live on the power-on reset only, so system resets keep them
  assign next_por_flag = power_on_reset_flag & ~(wr_flags & bus_req_i.wdata[`BIT_POWER_ON]);
  assign next_lvr_flag = lvr_event_i
    | (low_voltage_reset_flag & ~(wr_flags & bus_req_i.wdata[`BIT_LOW_VOLTAGE]));

  always_ff @(posedge clk_i or posedge por_reset_i)
  begin
    if (por_reset_i)
    begin
      power_on_reset_flag <= 1'b1;
      low_voltage_reset_flag <= 1'b0;
    end
    else
    begin
      power_on_reset_flag <= next_por_flag;
      low_voltage_reset_flag <= next_lvr_flag;
    end
  end

  // interrupt request straight from the flags and enables
  assign irq_o = (lock_change_flag & lock_change_irq_enable)
    | (self_clock_change_flag & self_clock_irq_enable);

  // read views; reserved bits are zero
  assign flags_view = {stop_entered_flag, power_on_reset_flag, low_voltage_reset_flag, lock_change_flag,
                       lock_status, track_status, self_clock_change_flag, self_clock_status};
  assign irq_en_view = {3'h0, lock_change_irq_enable, 2'h0, self_clock_irq_enable, 1'h0};
  assign next_rdata = !bus_req_i.rd ? 8'h00
    : hit_mult ? {2'h0, multiplier}
    : hit_refdiv ? {4'h0, ref_div}
    : hit_flags ? flags_view
    : hit_irq_en ? irq_en_view
    : 8'h00;

  // read data stands for one cycle only, zero otherwise
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= 8'h00;
    else
      rdata_o <= next_rdata;
  end

  // checks

  mult_frozen_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (bus_req_i.wr && hit_mult && sysclk_from_pll_select_i) |=> $stable(multiplier))
    else $error("multiplier changed while the PLL drives the system clock");

  mult_factor_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_mult_ok |=> (pll_mult_factor_o == ({2'h0, $past(bus_req_i.wdata[5:0])} + 8'h01) * 8'h02))
    else $error("multiplier factor does not follow the written field");

  refdiv_frozen_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (bus_req_i.wr && hit_refdiv && sysclk_from_pll_select_i) |=> $stable(ref_div))
    else $error("reference divider changed while the PLL drives the system clock");

  refdiv_factor_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    wr_refdiv_ok |=> (ref_div_factor_o == {1'b0, $past(bus_req_i.wdata[3:0])} + 5'h01))
    else $error("reference divider factor does not follow the written field");

  detector_restart_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    cfg_write |=> (detector_reinit_o && !lock_status && !track_status))
    else $error("config write did not restart lock and track detection");

  stop_clear_a: assert property (
    @(posedge clk_i) disable iff (reset_i || por_reset_i)
    (stop_request_write_i && !stop_entered_i) |=> !stop_entered_flag)
    else $error("stop flag survived a stop request write");

  stop_abort_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(stop_entered_flag) |-> ($past(stop_entered_i) && !$past(stop_aborted_i)))
    else $error("stop flag set without completed stop entry");

  por_clear_a: assert property (
    @(posedge clk_i) disable iff (por_reset_i)
    (wr_flags && bus_req_i.wdata[6]) |=> !power_on_reset_flag)
    else $error("power-on flag not cleared by a written one");

  lvr_set_a: assert property (
    @(posedge clk_i) disable iff (por_reset_i)
    lvr_event_i |=> low_voltage_reset_flag)
    else $error("low-voltage flag missed its event");

  lock_change_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $changed(lock_status) |=> lock_change_flag)
    else $error("lock change did not set its flag");

  lock_irq_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (lock_change_flag && lock_change_irq_enable) |-> irq_o)
    else $error("lock change interrupt not raised");

  lock_forced_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (self_clock_status && $past(self_clock_status)) |-> (!lock_status && !track_status))
    else $error("lock or track reads one in self-clock mode");

  self_change_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $changed(self_clock_status) |=> self_clock_change_flag)
    else $error("self-clock change did not set its flag");

  self_entry_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    $rose(self_clock_status) |-> $past(enter_self))
    else $error("self-clock mode entered without enables and clock loss");

  reserved_zero_a: assert property (
    @(posedge clk_i) disable iff (reset_i)
    (bus_req_i.rd && hit_irq_en) |=> (rdata_o[7:5] == 3'h0 && rdata_o[3:2] == 2'h0 && !rdata_o[0]))
    else $error("reserved interrupt enable bits read non-zero");

endmodule : clock_gen_status

//--- hw/level_sync.sv
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit is a slow level; no bus coherence across bits is promised.
*/
`timescale 1ns/1ps
module level_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i, // bus clock
  input wire logic reset_i, // async reset, active high
  input wire logic [WIDTH-1:0] async_i, // levels from another domain
  output logic [WIDTH-1:0] sync_o // levels safe to use
);
  logic [WIDTH-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule : level_sync
